// ### hdl/socket_system_control.sv
`timescale 1ns/1ps
`default_nettype none
module socket_system_control
   import sysctl_pkg::*;
#(
   parameter int UP_CYC = UP_DELAY_CYC,
   parameter int DN_CYC = DN_DELAY_CYC
)
(
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   // configuration access
   input wire logic CFG_SEL_I,
   input wire logic CFG_FUNC_I,
   input wire logic [7:0] CFG_ADDR_I,
   input wire logic CFG_WR_I,
   input wire logic CFG_RD_I,
   input wire logic [31:0] CFG_WDATA_I,
   output logic [31:0] CFG_RDATA_O,
   // socket events
   input wire logic [1:0] CARD_ACCESS_I,
   input wire logic [1:0] CARD_CB_I,
   input wire logic [1:0] CARD_IDLE_I,
   input wire logic [1:0] CARD_CLK_STOP_I,
   input wire logic [1:0] PROBE_ACTIVE_I,
   input wire logic PWR_REQ_I,
   input wire logic PWR_UP_I,
   // socket controls
   output logic [1:0] RSVD_PIN_OUT_O,
   output logic [1:0] RSVD_PIN_OE_O,
   output logic [1:0] SUPPLY_PROTECT_O,
   output logic [1:0] ADDR_HI_FLOAT_O,
   output logic [1:0] SM_CLK_EN_O,
   output logic BURST_DN_O,
   output logic BURST_UP_O,
   output logic SWITCH_CLK_INT_O,
   output logic SWITCH_DATA_O
);
   // ****************************************
   // registers
   // ****************************************
   sock_t sock [2];
   sock_t next_sock [2];
   logic burst_dn, burst_up, src_clk;
   logic next_burst_dn, next_burst_up, next_src_clk;
   logic [3:0] div, next_div;
   logic busy, up_wait, dn_wait, serial;
   logic [1:0] probe, next_probe;
   logic hit_wr, hit_rd;
   logic [31:0] rd, next_rd;
   assign hit_wr = CFG_SEL_I && CFG_WR_I && (CFG_ADDR_I == SYSCTL_OFFSET);
   assign hit_rd = CFG_SEL_I && CFG_RD_I && (CFG_ADDR_I == SYSCTL_OFFSET);

   function automatic logic [31:0] read_word(input sock_t s, input logic g_dn, input logic g_up,
      input logic g_clk, input logic b, input logic u, input logic d, input logic p);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[BIT_SRC_CLK] = g_clk;
      w[BIT_RSVD23] = 1'b0;
      w[BIT_PIN_DRIVE] = s.pin_drive;
      w[BIT_PROT_DIS] = s.prot_dis;
      w[BIT_VID_FLOAT] = s.vid_float;
      w[BIT_RSVD_LO +: 4] = s.rsvd;
      w[BIT_BURST_DN] = g_dn;
      w[BIT_BURST_UP] = g_up;
      w[BIT_ACTIVITY] = s.activity;
      w[BIT_RSVD12] = 1'b1;
      w[BIT_PWR_BUSY] = b;
      w[BIT_UP_WAIT] = u;
      w[BIT_DN_WAIT] = d;
      w[BIT_PROBE] = p;
      w[BIT_RSVD7] = 1'b0;
      w[BIT_GATE_EN] = s.gate_en;
      return w;
   endfunction : read_word

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      next_burst_dn = burst_dn;
      next_burst_up = burst_up;
      next_src_clk = src_clk;
      next_probe = PROBE_ACTIVE_I;
      next_div = div + 4'h1;
      next_rd = rd;
      for (int i = 0; i < 2; i++)
      begin
         next_sock[i] = sock[i];
         if (hit_wr && (CFG_FUNC_I == i[0]))
         begin
            next_sock[i].pin_drive = CFG_WDATA_I[BIT_PIN_DRIVE];
            next_sock[i].prot_dis = CFG_WDATA_I[BIT_PROT_DIS];
            next_sock[i].vid_float = CFG_WDATA_I[BIT_VID_FLOAT];
            next_sock[i].rsvd = CFG_WDATA_I[BIT_RSVD_LO +: 4];
            next_sock[i].gate_en = CFG_WDATA_I[BIT_GATE_EN];
         end
         // read clears, but a new access in the same cycle wins
         if (hit_rd && (CFG_FUNC_I == i[0]))
            next_sock[i].activity = 1'b0;
         if (CARD_ACCESS_I[i])
            next_sock[i].activity = 1'b1;
      end
      if (hit_wr && !CFG_FUNC_I)
      begin
         next_burst_dn = CFG_WDATA_I[BIT_BURST_DN];
         next_burst_up = CFG_WDATA_I[BIT_BURST_UP];
         next_src_clk = CFG_WDATA_I[BIT_SRC_CLK];
      end
      if (hit_rd)
         next_rd = read_word(sock[CFG_FUNC_I], burst_dn, burst_up, src_clk, busy, up_wait, dn_wait,
            probe[CFG_FUNC_I]);
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_N_I)
      begin
         for (int i = 0; i < 2; i++)
         begin
            sock[i].pin_drive <= SYSCTL_RESET[BIT_PIN_DRIVE];
            sock[i].prot_dis <= SYSCTL_RESET[BIT_PROT_DIS];
            sock[i].vid_float <= SYSCTL_RESET[BIT_VID_FLOAT];
            sock[i].rsvd <= RSVD_FIELD_RESET;
            sock[i].gate_en <= SYSCTL_RESET[BIT_GATE_EN];
            sock[i].activity <= 1'b0;
         end
         burst_dn <= SYSCTL_RESET[BIT_BURST_DN];
         burst_up <= SYSCTL_RESET[BIT_BURST_UP];
         src_clk <= SYSCTL_RESET[BIT_SRC_CLK];
         probe <= 2'h0;
         div <= 4'h0;
         rd <= 32'h0000_0000;
      end
      else
      begin
         sock <= next_sock;
         burst_dn <= next_burst_dn;
         burst_up <= next_burst_up;
         src_clk <= next_src_clk;
         probe <= next_probe;
         div <= next_div;
         rd <= next_rd;
      end
   end

   // ****************************************
   // power switch stream
   // ****************************************
   power_sequencer #(.UP_CYC(UP_CYC), .DN_CYC(DN_CYC), .BITS(STREAM_BITS)) u_seq (
      .clk(CLOCK_I),
      .rst_n(RST_N_I),
      .tick(div == 4'hf),
      .req(PWR_REQ_I),
      .up(PWR_UP_I),
      .busy(busy),
      .up_wait(up_wait),
      .dn_wait(dn_wait),
      .serial(serial)
   );

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_N_I)
      begin
         CFG_RDATA_O <= 32'h0000_0000;
         RSVD_PIN_OUT_O <= 2'h0;
         RSVD_PIN_OE_O <= 2'h0;
         SUPPLY_PROTECT_O <= 2'h0;
         ADDR_HI_FLOAT_O <= 2'h0;
         SM_CLK_EN_O <= 2'h3;
         BURST_DN_O <= 1'b0;
         BURST_UP_O <= 1'b0;
         SWITCH_CLK_INT_O <= 1'b0;
         SWITCH_DATA_O <= 1'b0;
      end
      else
      begin
         CFG_RDATA_O <= next_rd;
         for (int i = 0; i < 2; i++)
         begin
            RSVD_PIN_OUT_O[i] <= 1'b0;
            RSVD_PIN_OE_O[i] <= CARD_CB_I[i] && sock[i].pin_drive;
            SUPPLY_PROTECT_O[i] <= !CARD_CB_I[i] && !sock[i].prot_dis;
            ADDR_HI_FLOAT_O[i] <= !CARD_CB_I[i] && sock[i].vid_float;
            SM_CLK_EN_O[i] <= !(sock[i].gate_en && CARD_CB_I[i] && CARD_IDLE_I[i]
               && CARD_CLK_STOP_I[i]);
         end
         BURST_DN_O <= burst_dn;
         BURST_UP_O <= burst_up;
         SWITCH_CLK_INT_O <= src_clk;
         SWITCH_DATA_O <= serial;
      end
   end

   activity_set_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      CARD_ACCESS_I[0] |=> sock[0].activity) else $error("activity flag missed access");
   func1_no_global_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      hit_wr && CFG_FUNC_I |=> $stable(burst_up) && $stable(burst_dn))
      else $error("function 1 changed a global field");
   burst_up_out_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      BURST_UP_O |-> $past(burst_up)) else $error("upstream burst without enable");
   burst_dn_out_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      BURST_DN_O |-> $past(burst_dn)) else $error("downstream burst without enable");
   pin_drive_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      CARD_CB_I[0] && sock[0].pin_drive |=> RSVD_PIN_OE_O[0] && !RSVD_PIN_OUT_O[0])
      else $error("reserved pins not driven low");
   vid_float_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      !CARD_CB_I[1] && sock[1].vid_float |=> ADDR_HI_FLOAT_O[1]) else $error("address pins not floated");
   protect_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      !CARD_CB_I[1] && !sock[1].prot_dis |=> SUPPLY_PROTECT_O[1]) else $error("supply protection off");
   clock_gate_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      sock[0].gate_en && CARD_CB_I[0] && CARD_IDLE_I[0] && CARD_CLK_STOP_I[0] |=> !SM_CLK_EN_O[0])
      else $error("idle socket still clocked");
   rsvd_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      hit_rd |=> CFG_RDATA_O[BIT_RSVD12] && !CFG_RDATA_O[BIT_RSVD23] && !CFG_RDATA_O[BIT_RSVD7])
      else $error("reserved bits read wrong");
   probe_follow_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      PROBE_ACTIVE_I[1] |=> probe[1]) else $error("probe flag not set");
endmodule : socket_system_control
`default_nettype wire

// ### pkg/sysctl_pkg.sv
package sysctl_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] SYSCTL_OFFSET = 8'h80;
   localparam logic [31:0] SYSCTL_RESET = 32'h0044_9060;
   localparam int BIT_SRC_CLK = 27;
   localparam int BIT_RSVD23 = 23;
   localparam int BIT_PIN_DRIVE = 22;
   localparam int BIT_PROT_DIS = 21;
   localparam int BIT_VID_FLOAT = 20;
   localparam int BIT_RSVD_LO = 16;
   localparam int BIT_BURST_DN = 15;
   localparam int BIT_BURST_UP = 14;
   localparam int BIT_ACTIVITY = 13;
   localparam int BIT_RSVD12 = 12;
   localparam int BIT_PWR_BUSY = 11;
   localparam int BIT_UP_WAIT = 10;
   localparam int BIT_DN_WAIT = 9;
   localparam int BIT_PROBE = 8;
   localparam int BIT_RSVD7 = 7;
   localparam int BIT_GATE_EN = 6;
   localparam logic [3:0] RSVD_FIELD_RESET = 4'h4;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLOCK_HZ = 10_000_000;
   localparam int UP_DELAY_US = 100;
   localparam int DN_DELAY_US = 100;
   localparam int UP_DELAY_CYC = (UP_DELAY_US * (CLOCK_HZ / 1_000_000));
   localparam int DN_DELAY_CYC = (DN_DELAY_US * (CLOCK_HZ / 1_000_000));
   localparam int STREAM_BITS = 16;
   // per-socket field copy
   typedef struct packed {
      logic pin_drive;
      logic prot_dis;
      logic vid_float;
      logic [3:0] rsvd;
      logic gate_en;
      logic activity;
   } sock_t;
endpackage : sysctl_pkg

// ### hdl/power_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module power_sequencer
   import sysctl_pkg::*;
#(
   parameter int UP_CYC = UP_DELAY_CYC,
   parameter int DN_CYC = DN_DELAY_CYC,
   parameter int BITS = STREAM_BITS
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   // request
   input wire logic req,
   input wire logic up,
   // status
   output logic busy,
   output logic up_wait,
   output logic dn_wait,
   output logic serial
);
   // ****************************************
   // stream then settle
   // ****************************************
   typedef enum logic [2:0] {IDLE = 3'b001, SEND = 3'b010, WAIT = 3'b100} st_t;
   st_t st, next_st;
   logic [15:0] cnt, next_cnt;
   logic dir_up, next_dir_up;
   always_comb
   begin
      next_st = st;
      next_cnt = cnt;
      next_dir_up = dir_up;
      case (st)
         IDLE:
         begin
            if (req)
            begin
               next_st = SEND;
               next_dir_up = up;
               next_cnt = 16'(BITS - 1);
            end
         end
         SEND:
         begin
            if (tick)
            begin
               if (cnt == 16'h0000)
               begin
                  next_st = WAIT;
                  next_cnt = dir_up ? 16'(UP_CYC - 1) : 16'(DN_CYC - 1);
               end
               else
                  next_cnt = cnt - 16'h0001;
            end
         end
         WAIT:
         begin
            if (cnt == 16'h0000)
               next_st = IDLE;
            else
               next_cnt = cnt - 16'h0001;
         end
         default: next_st = IDLE;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st <= IDLE;
         cnt <= 16'h0000;
         dir_up <= 1'b0;
      end
      else
      begin
         st <= next_st;
         cnt <= next_cnt;
         dir_up <= next_dir_up;
      end
   end
   assign busy = (st != IDLE);
   assign up_wait = (st == WAIT) && dir_up;
   assign dn_wait = (st == WAIT) && !dir_up;
   assign serial = (st == SEND) && dir_up;
   busy_until_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st == IDLE) && req |=> busy [*2]) else $error("busy did not follow request");
endmodule : power_sequencer
`default_nettype wire

// ### tb/card_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// card pair: socket 0 holds a cardbus card, socket 1 a 16-bit card
// ****************************************
module card_model
(
   input wire logic clk,
   input wire logic [1:0] access_req,
   input wire logic [1:0] idle_req,
   input wire logic [1:0] probe_req,
   output logic [1:0] card_access,
   output logic [1:0] card_cb,
   output logic [1:0] card_idle,
   output logic [1:0] card_clk_stop,
   output logic [1:0] probe_active
);
   initial
   begin
      card_access = 2'h0;
      card_cb = 2'h1;
      card_idle = 2'h0;
      card_clk_stop = 2'h0;
      probe_active = 2'h0;
   end
   // changes land on the falling edge, away from the sampling edge
   always @(negedge clk)
   begin
      card_access <= access_req;
      card_idle <= idle_req & card_cb;
      card_clk_stop <= idle_req & card_cb;
      probe_active <= probe_req;
   end
endmodule : card_model
`default_nettype wire

// ### tb/card_socket_system_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module card_socket_system_control_tb_top
   import sysctl_pkg::*;
;
   logic clk, rst_n, sel, func, wr, rd, pwr_req, pwr_up;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d, e;
   logic [1:0] acc_req, idle_req, probe_req, c_acc, c_cb, c_idle, c_stop, c_probe;
   logic [1:0] pin_out, pin_oe, protect, afloat, sm_en;
   logic b_dn, b_up, clk_int, sdata;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   // only bits 27 down to 6 live in this block; the rest read as zero
   localparam logic [31:0] KEPT = 32'h0fff_ffc0;
   socket_system_control #(.UP_CYC(8), .DN_CYC(8)) u_socket_system_control (
      .CLOCK_I(clk), .RST_N_I(rst_n), .CFG_SEL_I(sel), .CFG_FUNC_I(func), .CFG_ADDR_I(addr),
      .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata),
      .CARD_ACCESS_I(c_acc), .CARD_CB_I(c_cb), .CARD_IDLE_I(c_idle), .CARD_CLK_STOP_I(c_stop),
      .PROBE_ACTIVE_I(c_probe), .PWR_REQ_I(pwr_req), .PWR_UP_I(pwr_up), .RSVD_PIN_OUT_O(pin_out),
      .RSVD_PIN_OE_O(pin_oe), .SUPPLY_PROTECT_O(protect), .ADDR_HI_FLOAT_O(afloat), .SM_CLK_EN_O(sm_en),
      .BURST_DN_O(b_dn), .BURST_UP_O(b_up), .SWITCH_CLK_INT_O(clk_int), .SWITCH_DATA_O(sdata));
   card_model u_card_model (.clk(clk), .access_req(acc_req), .idle_req(idle_req), .probe_req(probe_req),
      .card_access(c_acc), .card_cb(c_cb), .card_idle(c_idle), .card_clk_stop(c_stop),
      .probe_active(c_probe));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ****************************************
   // helpers
   // ****************************************
   task automatic end_sim;
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic cfg_rd(input logic f, output logic [31:0] q);
      @(negedge clk);
      sel = 1'b1; func = f; rd = 1'b1;
      @(negedge clk);
      sel = 1'b0; rd = 1'b0;
      q = rdata;
   endtask : cfg_rd
   task automatic cfg_wr(input logic f, input logic [31:0] v);
      @(negedge clk);
      sel = 1'b1; func = f; wr = 1'b1; wdata = v;
      @(negedge clk);
      sel = 1'b0; wr = 1'b0;
      repeat (2) @(negedge clk);
   endtask : cfg_wr
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      cfg_rd(1'b0, d); chk(d, SYSCTL_RESET & KEPT, "f0 reset");
      cfg_rd(1'b1, d); chk(d, SYSCTL_RESET & KEPT, "f1 reset");
      chk({b_dn, b_up}, 32'h2, "burst reset");
      chk({pin_oe, pin_out}, 32'h4, "pin drive reset");
      chk({protect, afloat}, 32'h8, "protect reset");
   endtask : t_reset
   task automatic t_sockets;
      // rsvd field written back at its reset value, reserved bits 23, 12 and 7 written inverted
      cfg_wr(1'b1, (SYSCTL_RESET ^ 32'h0000_d000) | 32'h0030_0080 | 32'h0080_0000);
      e = (SYSCTL_RESET | 32'h0030_0000) & KEPT;
      cfg_rd(1'b1, d); chk(d, e, "f1 socket write");
      cfg_rd(1'b0, d); chk(d, SYSCTL_RESET & KEPT, "f0 untouched");
      chk({b_dn, b_up}, 32'h2, "f1 burst ignored");
      chk({protect, afloat}, 32'h2, "protect off float on");
      cfg_wr(1'b0, (SYSCTL_RESET & 32'hffbf_ffff) ^ 32'h0800_c000);
      chk({pin_oe, pin_out}, 32'h0, "pins floated");
      chk({b_dn, b_up, clk_int}, 32'h3, "burst swap");
      cfg_rd(1'b1, d); chk(d, e ^ 32'h0800_c000, "globals shared");
      cfg_wr(1'b0, SYSCTL_RESET);
      chk({b_dn, b_up, clk_int, pin_oe}, 32'h11, "restored");
   endtask : t_sockets
   task automatic t_activity;
      @(negedge clk); acc_req = 2'h1;
      @(negedge clk); acc_req = 2'h0;
      repeat (2) @(negedge clk);
      cfg_rd(1'b1, d); chk(d[BIT_ACTIVITY], 1'b0, "other socket idle");
      cfg_rd(1'b0, d); chk(d[BIT_ACTIVITY], 1'b1, "activity set");
      cfg_rd(1'b0, d); chk(d[BIT_ACTIVITY], 1'b0, "cleared on read");
      probe_req = 2'h2;
      repeat (3) @(negedge clk);
      cfg_rd(1'b1, d); chk(d[BIT_PROBE], 1'b1, "probe f1");
      cfg_rd(1'b0, d); chk(d[BIT_PROBE], 1'b0, "probe f0");
      probe_req = 2'h0;
      repeat (3) @(negedge clk);
      cfg_rd(1'b1, d); chk(d[BIT_PROBE], 1'b0, "probe done");
   endtask : t_activity
   task automatic t_power(input logic up);
      logic seen_up, seen_dn, seen_sd;
      int n;
      seen_up = 1'b0; seen_dn = 1'b0; seen_sd = 1'b0; n = 0;
      @(negedge clk); pwr_req = 1'b1; pwr_up = up;
      @(negedge clk); pwr_req = 1'b0;
      cfg_rd(1'b1, d); chk(d[BIT_PWR_BUSY], 1'b1, "stream busy");
      while (d[BIT_PWR_BUSY] !== 1'b0 && n < 400)
      begin
         cfg_rd(1'b0, d);
         seen_up = seen_up | d[BIT_UP_WAIT];
         seen_dn = seen_dn | d[BIT_DN_WAIT];
         seen_sd = seen_sd | sdata;
         n++;
      end
      // 16 ticks of 16 cycles plus the settle, read every 2 cycles: about 128 polls
      chk({31'h0, (n > 100) && (n < 150)}, 32'h1, "busy length");
      chk({seen_up, seen_dn, d[BIT_UP_WAIT], d[BIT_DN_WAIT]}, {up, ~up, 2'b00}, "wait flags");
      chk({31'h0, seen_sd}, {31'h0, up}, "stream data");
   endtask : t_power
   task automatic t_gate;
      idle_req = 2'h3;
      repeat (4) @(negedge clk);
      chk(sm_en, 2'h2, "socket 0 clock gated");
      cfg_wr(1'b0, SYSCTL_RESET & 32'hffff_ffbf);
      chk(sm_en, 2'h3, "gating off");
      cfg_wr(1'b0, SYSCTL_RESET);
      idle_req = 2'h0;
      repeat (4) @(negedge clk);
      chk(sm_en, 2'h3, "card busy again");
   endtask : t_gate
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         end_sim();
      end
   end
   initial
   begin
      rst_n = 1'b0; sel = 1'b0; func = 1'b0; wr = 1'b0; rd = 1'b0; addr = SYSCTL_OFFSET;
      wdata = 32'h0; pwr_req = 1'b0; pwr_up = 1'b0;
      acc_req = 2'h0; idle_req = 2'h0; probe_req = 2'h0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_reset();
      t_sockets();
      t_activity();
      t_power(1'b1);
      t_power(1'b0);
      t_gate();
      end_sim();
   end
endmodule : card_socket_system_control_tb_top
`default_nettype wire
